// [hdl/scp_sincos.v]
// sine/cosine pipeline top: angle fold, two quarter-wave cores, sign and range handling
// assumes angle_in and en come from logic on clk; no registers reach software
`timescale 1ns/100ps
`include "scp_consts.vh"

module scp_sincos (
   // clock, reset, stall
   input wire clk,
   input wire rst_n,
   input wire en,
   // angle sample
   input wire [17:0] angle_in,
   // results
   output reg [16:0] sine_out,
   output reg [16:0] cosine_out
);

reg [16:0] next_sin_arg;
reg [16:0] next_cos_arg;
reg next_cos_neg;
reg [16:0] sin_arg;
reg [16:0] cos_arg;
reg [`SCP_F_W-1:0] flag_s1;
reg [`SCP_F_W-1:0] flag_q1;
reg [`SCP_F_W-1:0] flag_q2;
reg [`SCP_F_W-1:0] flag_q3;
wire [17:0] abs_angle;
wire [17:0] fold_diff;
wire out_range;
wire [15:0] sin_mag;
wire [15:0] cos_mag;
wire [16:0] sin_pos;
wire [16:0] cos_pos;

// magnitude of the angle; the most negative code wraps high and lands out of range
assign abs_angle = angle_in[17] ? (~angle_in + 18'h00001) : angle_in; // RULE_01
assign out_range = abs_angle > `SCP_PI_LIM; // RULE_03
// pi minus the angle; only the low 17 bits matter once the angle is past pi/2
assign fold_diff = `SCP_PI_FOLD - abs_angle;

// fold 0..pi onto two quarter-wave arguments
always @*
begin
   if (abs_angle[16:0] <= `SCP_HALF_PI)
   begin
      next_sin_arg = abs_angle[16:0];
      next_cos_arg = `SCP_HALF_PI - abs_angle[16:0];
      next_cos_neg = 1'b0;
   end
   else
   begin
      next_sin_arg = fold_diff[16:0];
      next_cos_arg = abs_angle[16:0] - `SCP_HALF_PI;
      next_cos_neg = 1'b1;
   end
end

// capture stage and flag delay line, matching the three core stages
always @(posedge clk)
begin
   if (!rst_n)
   begin
      sin_arg <= 17'h00000;
      cos_arg <= 17'h00000;
      flag_s1 <= 3'h0;
      flag_q1 <= 3'h0;
      flag_q2 <= 3'h0;
      flag_q3 <= 3'h0;
   end
   else if (en) // RULE_05
   begin
      sin_arg <= next_sin_arg;
      cos_arg <= next_cos_arg;
      flag_s1[`SCP_F_OOR] <= out_range; // RULE_04
      flag_s1[`SCP_F_SNEG] <= angle_in[17];
      flag_s1[`SCP_F_CNEG] <= next_cos_neg;
      // flags ride beside the data so both results stay paired
      flag_q1 <= flag_s1; // RULE_12
      flag_q2 <= flag_q1;
      flag_q3 <= flag_q2;
   end
end

// one core per result, so both finish in the same cycle
scp_quarter u_sin (
   .clk(clk),
   .rst_n(rst_n),
   .en(en),
   .arg(sin_arg),
   .mag(sin_mag)
); // RULE_12

scp_quarter u_cos (
   .clk(clk),
   .rst_n(rst_n),
   .en(en),
   .arg(cos_arg),
   .mag(cos_mag)
);

assign sin_pos = {1'b0, sin_mag};
assign cos_pos = {1'b0, cos_mag};

// output stage: fifth register, new pair every enabled cycle, held otherwise
always @(posedge clk)
begin
   if (!rst_n)
   begin
      sine_out <= 17'h00000;
      cosine_out <= 17'h00000;
   end
   else if (en) // RULE_13
   begin
      if (flag_q3[`SCP_F_OOR])
      begin
         sine_out <= `SCP_SIN_DEF; // RULE_04
         cosine_out <= `SCP_COS_DEF;
      end
      else
      begin
         // sine is odd, cosine even; fold sign added back here
         sine_out <= flag_q3[`SCP_F_SNEG] ? (~sin_pos + `SCP_ONE_LSB) : sin_pos; // RULE_02
         cosine_out <= flag_q3[`SCP_F_CNEG] ? (~cos_pos + `SCP_ONE_LSB) : cos_pos; // RULE_06
      end
   end
end // RULE_08

endmodule // scp_sincos

// [hdl/scp_consts.vh]
// constants for the sine/cosine pipeline: formats, fold limits, scale factors, coefficient table
// assumes it is included by its bare name from every design file of the block
// How it works
// RULE_01: angle is 18-bit two's complement radians, 2 integer and 15 fraction bits.
// RULE_02: sine and cosine come out as 17-bit two's complement, 15 fraction bits.
// RULE_03: supplying logic keeps the angle between minus pi and plus pi inclusive.
// RULE_04: out-of-range angle gives sine zero and cosine minus one.
// RULE_05: angle is captured only on rising clock edges with enable high.
// RULE_06: results appear five enabled cycles after the angle is presented.
// RULE_07: enable low freezes every pipeline stage; progress resumes with enable high.
// RULE_08: one new angle taken and one result pair given per enabled cycle.
// RULE_09: in-range results stay within a small absolute error of true values.
// RULE_10: both results come from a quarter-wave sine quadratic with segment coefficients.
// RULE_11: datapath is fixed-point throughout, nothing floating.
// RULE_12: sine and cosine of one angle leave on the same cycle.
// RULE_13: outputs hold their previous values while enable is low.
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// data formats
`define SCP_ANGLE_W 18
`define SCP_RES_W 17
`define SCP_ARG_W 17
`define SCP_MAG_W 16

// fold limits in 2^-15 radian units
`define SCP_PI_LIM 18'h1921F
`define SCP_PI_FOLD 18'h19220
`define SCP_HALF_PI 17'h0C910

// fixed results for angles outside the valid range, and the one-LSB step used to negate results
`define SCP_SIN_DEF 17'h00000
`define SCP_COS_DEF 17'h18000
`define SCP_ONE_LSB 17'h00001

// quarter-wave scale factors, segment midpoint and clip limits
`define SCP_K_TURN 16'hA2FA
`define SCP_K_RAD 17'h0C910
`define SCP_U_MAX 17'h0FFFF
`define SCP_SEG_MID 13'h0800
`define SCP_UNIT 19'h08000
`define SCP_MAG_ONE 16'h8000
`define SCP_ZERO 19'h00000

// flag bit positions carried alongside the data
`define SCP_F_OOR 0
`define SCP_F_SNEG 1
`define SCP_F_CNEG 2
`define SCP_F_W 3

// sine of segment midpoints, (2k+1)*pi/64, scaled by 2^15
`define SCP_T00 15'h0648
`define SCP_T01 15'h12C8
`define SCP_T02 15'h1F1A
`define SCP_T03 15'h2B1F
`define SCP_T04 15'h36BA
`define SCP_T05 15'h41CE
`define SCP_T06 15'h4C40
`define SCP_T07 15'h55F5
`define SCP_T08 15'h5ED7
`define SCP_T09 15'h66CF
`define SCP_T10 15'h6DCA
`define SCP_T11 15'h73B6
`define SCP_T12 15'h7884
`define SCP_T13 15'h7C2A
`define SCP_T14 15'h7E9D
`define SCP_T15 15'h7FD9

`endif

// [hdl/scp_quarter.v]
// quarter-wave sine core: three register stages, sine magnitude of 0..pi/2
// assumes the caller folds the angle into 0..pi/2 and delays its own flags by three stages
`timescale 1ns/100ps
`include "scp_consts.vh"

module scp_quarter (
   // clock, reset, stall
   input wire clk,
   input wire rst_n,
   input wire en,
   // folded angle, unsigned radians with 15 fraction bits
   input wire [16:0] arg,
   // sine magnitude, 0..1 with 15 fraction bits
   output reg [15:0] mag
);

reg [3:0] seg;
reg [11:0] off;
reg signed [12:0] delta;
reg [14:0] coef_s;
reg [14:0] coef_c;
wire [32:0] turn_prod;
wire [16:0] turn;
wire [16:0] turn_clip;
wire signed [12:0] off_c;
wire signed [29:0] rad_prod;
wire signed [28:0] slope_prod;
wire signed [25:0] dsq;
wire [21:0] curve_prod;
wire signed [18:0] sum;

// segment coefficient table, a constant rom
function [14:0] scp_rom;
   input [3:0] idx;
   begin
      case (idx)
         4'h0: scp_rom = `SCP_T00;
         4'h1: scp_rom = `SCP_T01;
         4'h2: scp_rom = `SCP_T02;
         4'h3: scp_rom = `SCP_T03;
         4'h4: scp_rom = `SCP_T04;
         4'h5: scp_rom = `SCP_T05;
         4'h6: scp_rom = `SCP_T06;
         4'h7: scp_rom = `SCP_T07;
         4'h8: scp_rom = `SCP_T08;
         4'h9: scp_rom = `SCP_T09;
         4'hA: scp_rom = `SCP_T10;
         4'hB: scp_rom = `SCP_T11;
         4'hC: scp_rom = `SCP_T12;
         4'hD: scp_rom = `SCP_T13;
         4'hE: scp_rom = `SCP_T14;
         default: scp_rom = `SCP_T15;
      endcase
   end
endfunction

// radians to a 16-bit quarter-turn fraction; pi/2 itself clips to the top code
assign turn_prod = arg * `SCP_K_TURN; // RULE_11
assign turn = turn_prod[31:15];
assign turn_clip = (turn > `SCP_U_MAX) ? `SCP_U_MAX : turn;

// offset from the segment midpoint, back in radians
assign off_c = {1'b0, off} - `SCP_SEG_MID;
assign rad_prod = off_c * $signed(`SCP_K_RAD);

// taylor terms around the midpoint: s + c*d - s*d*d/2
assign slope_prod = $signed({1'b0, coef_c}) * delta; // RULE_10
assign dsq = delta * delta;
assign curve_prod = coef_s * dsq[21:15];
assign sum = $signed({4'h0, coef_s}) + $signed({{5{slope_prod[28]}}, slope_prod[28:15]})
   - $signed({13'h0000, curve_prod[21:16]});

// three stages, all frozen while en is low
always @(posedge clk)
begin
   if (!rst_n)
   begin
      seg <= 4'h0;
      off <= 12'h000;
      delta <= 13'h0000;
      coef_s <= 15'h0000;
      coef_c <= 15'h0000;
      mag <= 16'h0000;
   end
   else if (en) // RULE_07
   begin
      seg <= turn_clip[15:12];
      off <= turn_clip[11:0];
      delta <= rad_prod[28:16];
      // cosine at the midpoint equals the mirrored segment's sine
      coef_s <= scp_rom(seg); // RULE_10
      coef_c <= scp_rom(~seg);
      // clip keeps truncation ripple at the ends inside 0..1
      if (sum < $signed(`SCP_ZERO))
         mag <= 16'h0000;
      else if (sum > $signed(`SCP_UNIT))
         mag <= `SCP_MAG_ONE; // RULE_09
      else
         mag <= sum[15:0];
   end
end

endmodule // scp_quarter

// [tb/scp_src.sv]
// angle source: boundary angles after each reset, then random words
// assumes clk and rst_n from the bench; stall_pct sets how often en drops
`timescale 1ns/100ps
module scp_src (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // share of edges with en low, in percent
   input wire [7:0] stall_pct,
   // stream into the pipeline
   output reg en,
   output reg [17:0] angle_in
);
   reg [17:0] tab [0:7];
   integer idx;
   // both range ends and their out-of-range neighbours come first
   initial
   begin
      tab[0] = 18'h00000;
      tab[1] = 18'h1921F;
      tab[2] = 18'h19220;
      tab[3] = 18'h26DE1;
      tab[4] = 18'h26DE0;
      tab[5] = 18'h20000;
      tab[6] = 18'h0C910;
      tab[7] = 18'h04872;
      idx = 0;
      en = 1'b0;
      angle_in = 18'h00000;
      // seeded in the same process that draws, so the seed really steers the stream
      void'($urandom(60));
      // random words also leave the valid range on purpose
      forever
      begin
         @(posedge clk);
         en <= rst_n && (($urandom % 100) >= stall_pct);
         angle_in <= (idx < 8) ? tab[idx] : 18'($urandom);
         idx <= (!rst_n) ? 0 : ((idx < 8) ? idx + 1 : idx);
      end
   end
endmodule // scp_src

// [tb/scp_sincos_monitor.sv]
// port checks on the sine/cosine pipeline
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module scp_sincos_monitor (
   // clock, reset, stall
   input wire clk,
   input wire rst_n,
   input wire en,
   // angle and results
   input wire [17:0] angle_in,
   input wire [16:0] sine_out,
   input wire [16:0] cosine_out
);
   wire signed [17:0] a = angle_in;
   wire oor = a > $signed(18'h1921F) || a < $signed(18'h26DE1);
   // angle bands whose signs are certain despite the error bound
   wire s_pos = a >= $signed(18'h02000) && a <= $signed(18'h17000);
   wire s_neg = a >= $signed(18'h29000) && a <= $signed(18'h3E000);
   wire c_pos = a >= $signed(18'h34000) && a <= $signed(18'h0C000);
   wire c_neg = !oor && (a >= $signed(18'h0D800) || a <= $signed(18'h32800));
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // taken, then four more enabled edges; a stall in between only delays
   sequence took(c);
      en && c ##1 en [*4];
   endsequence
   sequence took_stalled(c);
      en && c ##1 !en ##1 en [*4];
   endsequence
   a_oor_default: assert property (took(oor) |=> sine_out == 17'h00000 && cosine_out == 17'h18000)
      else $error("out of range angle gave a wrong pair");
   a_stall_delays_oor: assert property (took_stalled(oor) |=> cosine_out == 17'h18000)
      else $error("stall broke the latency count");
   a_hold_when_stalled: assert property (!en |=> $stable(sine_out) && $stable(cosine_out))
      else $error("result moved while stalled");
   a_sine_sign_pos: assert property (took(s_pos) |=> !sine_out[16] && sine_out != 17'h00000)
      else $error("sine not positive on time");
   a_sine_sign_neg: assert property (took(s_neg) |=> sine_out[16])
      else $error("sine not negative on time");
   a_cosine_sign_pos: assert property (took(c_pos) |=> !cosine_out[16] && cosine_out != 17'h00000)
      else $error("cosine not positive on time");
   a_cosine_sign_neg: assert property (took(c_neg) |=> cosine_out[16])
      else $error("cosine not negative on time");
   a_output_range: assert property ($signed(sine_out) <= $signed(17'h08000) && $signed(sine_out) >= $signed(17'h18000))
      else $error("sine beyond one");
endmodule // scp_sincos_monitor
bind scp_sincos scp_sincos_monitor i_scp_sincos_monitor (.clk(clk), .rst_n(rst_n), .en(en),
   .angle_in(angle_in), .sine_out(sine_out), .cosine_out(cosine_out));

// [tb/scp_sincos_tb_top.sv]
// bench for the sine/cosine pipeline with a reference pipeline of angles
// assumes the source model drives en and angle_in at rising edges
`timescale 1ns/100ps
module scp_sincos_tb_top;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] stall_pct = 8'h00;
   wire en;
   wire [17:0] angle_in;
   wire [16:0] sine_out;
   wire [16:0] cosine_out;
   integer mismatches = 0;
   integer compares = 0;
   integer cnt = 0;
   integer k;
   integer w;
   reg [17:0] hist [0:4];
   // 25 MHz
   always #20 clk = ~clk;
   scp_src i_scp_src (.clk(clk), .rst_n(rst_n), .stall_pct(stall_pct), .en(en), .angle_in(angle_in));
   scp_sincos i_scp_sincos (.clk(clk), .rst_n(rst_n), .en(en), .angle_in(angle_in),
      .sine_out(sine_out), .cosine_out(cosine_out));
   task bad(input string msg);
   begin
      mismatches = mismatches + 1;
      $display("BAD %0t %s", $time, msg);
   end
   endtask
   // real sine/cosine as reference; out-of-range must match exactly
   task check(input [17:0] a);
      real ang, ds, dc;
   begin
      compares = compares + 1;
      ang = $itor($signed(a)) / 32768.0;
      ds = $itor($signed(sine_out)) / 32768.0 - $sin(ang);
      dc = $itor($signed(cosine_out)) / 32768.0 - $cos(ang);
      if ($signed(a) > $signed(18'h1921F) || $signed(a) < $signed(18'h26DE1))
      begin
         if (sine_out !== 17'h00000 || cosine_out !== 17'h18000)
            bad("default pair wrong");
      end
      else if (^{sine_out, cosine_out} === 1'bx || ds * ds > 0.0000000289 || dc * dc > 0.0000000289)
         bad("result off by more than the bound");
   end
   endtask
   task end_of_test;
   begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   // only enabled edges move the reference, so stalls add delay one for one
   always @(posedge clk)
   begin
      if (!rst_n)
         cnt <= 0;
      else if (en)
      begin
         for (k = 4; k > 0; k = k - 1)
            hist[k] <= hist[k - 1];
         hist[0] <= angle_in;
         cnt <= cnt + 1;
      end
   end
   // every settled cycle is compared, stalled ones too
   always @(negedge clk)
      if (rst_n && cnt >= 5)
         check(hist[4]);
   // prompt, stalling, mid-run reset, prompt again, then mostly stalled traffic
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (w = 0; w < 100 && cnt < 5; w = w + 1)
         @(posedge clk);
      if (cnt < 5)
         bad("pipeline never filled");
      else
      begin
         repeat (400) @(posedge clk);
         stall_pct <= 8'h1E;
         repeat (2000) @(posedge clk);
         rst_n <= 1'b0;
         repeat (2) @(posedge clk);
         rst_n <= 1'b1;
         stall_pct <= 8'h00;
         repeat (300) @(posedge clk);
         stall_pct <= 8'h5A;
         repeat (2000) @(posedge clk);
      end
      end_of_test;
   end
endmodule // scp_sincos_tb_top
